// ### timer_pkg.sv
// package of register offsets, field positions, reset values and timing counts
// for the power-down and balance timer block; assumes a 200 MHz pclk
package timer_pkg;
  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ           = 200_000_000;
  localparam int unsigned FILTER_US        = 130;          // pin filter time
  localparam int unsigned POWERON_US       = 5;            // initial power-on acceptance
  localparam int unsigned TICK_MS          = 4469;         // 71.5 s / 16, in ms
  localparam int unsigned FILTER_CYCLES    = FILTER_US * (CLK_HZ / 1_000_000);
  localparam int unsigned POWERON_CYCLES   = POWERON_US * (CLK_HZ / 1_000_000);
  localparam longint unsigned TICK_CYCLES  = longint'(TICK_MS) * (CLK_HZ / 1000);
  localparam int unsigned SUBSTEPS         = 16;           // ticks per 71.5 s step
  localparam int unsigned NUM_OUT          = 6;
  localparam int unsigned TIMER_W          = 5;            // 0..31 steps = 0..36.9 min

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_SHUT_DELAY = 8'h04;
  localparam logic [7:0] ADDR_BALANCE    = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0C;
  localparam logic [7:0] ADDR_ON_TIME0   = 8'h10;          // six words follow
  localparam int unsigned SOFT_PD_BIT    = 8;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 5'h00;
  localparam logic [5:0]  BALANCE_RESET  = 6'h00;

  typedef enum logic [1:0] {
    PWR_ON    = 2'b00,
    PWR_DELAY = 2'b01,
    PWR_SOFT  = 2'b10,
    PWR_HARD  = 2'b11
  } pwr_state_t;
endpackage : timer_pkg

// ### timer_if.sv
// interface carrying the tick and step outputs of the prescaler to the timers, and the restart back
// assumes a single pclk domain
`timescale 1ns/1ps
interface timer_if;
  logic       tick;        // 4.5 s comparison tick
  logic       step;        // 71.5 s step tick
  logic       restart;     // clear the prescaler
  modport prescaler (input restart, output tick, step);
  modport user      (output restart, input tick, step);
endinterface : timer_if

// ### tick_prescaler.sv
// prescaler giving a 4.5 s tick and a 71.5 s step from pclk
// assumes pclk at the package rate; TICK_CYCLES may be shortened by parameter
`timescale 1ns/1ps
module tick_prescaler #(
  parameter longint unsigned TICK_CYCLES = timer_pkg::TICK_CYCLES
) (
  input  wire logic pclk,     // clock
  input  wire logic presetn,  // async reset, active low
  timer_if.prescaler tif      // tick outputs
);
  import timer_pkg::*;
  logic [39:0] cnt;
  logic [3:0]  sub;

  // ==========================================================================
  // tick counter
  // ==========================================================================
  // free-running divider, restarted whenever the balance counter restarts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      sub <= '0;
    end else if (tif.restart) begin
      cnt <= '0;
      sub <= '0;
    end else if (cnt == 40'(TICK_CYCLES - 1)) begin
      cnt <= '0;
      sub <= sub + 4'h1;
    end else begin
      cnt <= cnt + 40'h1;
    end
  end
  assign tif.tick = (cnt == 40'(TICK_CYCLES - 1));
  assign tif.step = tif.tick && (sub == 4'(SUBSTEPS - 1));
endmodule : tick_prescaler

// ### pd_balance_top.sv
// top of the power-down and cell-balance timer block, APB slave
// assumes power_down_n already synchronous to pclk; presetn is the power-on reset
// Notes on behaviour
// - pin low must hold about 130 us before hardware power-down starts
// - pin high must hold about 130 us before leaving power-down
// - at first power-up the filter is skipped; accept power-on after 5 us
// - control bit 8 enters software power-down
// - delay timer 0..36.9 min in 71.5 s steps
// - pin fall or bit 8 starts delay; at expiry power down if pin low
// - delay register resets to zero
// - writing delay while running restarts count; zero checks pin at once
// - a later pin rise does not cancel a running delay
// - balance outputs follow the balance register, reset zero
// - zero delay: pin fall kills outputs at once; else at delay expiry
// - on-time registers 0..36.9 min, zero means disabled
// - nonzero balance write starts the shared counter and outputs
// - on expiry output off, balance register cleared, on-times kept
// - all six on-time registers reset to zero
// - counter compared with on-times every 4.5 s
// - balance register writes override the timers
// - accepted pin fall powers down all circuitry
// - write to an active output's on-time restarts counter; zero turns off
// - write to an inactive output's on-time leaves counter alone
`timescale 1ns/1ps
module pd_balance_top #(
  parameter longint unsigned TICK_CYCLES = timer_pkg::TICK_CYCLES
) (
  input  wire logic        pclk,            // bus and core clock
  input  wire logic        presetn,         // async reset, active low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb access phase
  input  wire logic        pwrite,          // apb direction
  input  wire logic [7:0]  paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error
  input  wire logic        power_down_n,    // power-down pin, active low
  output logic [timer_pkg::NUM_OUT-1:0] balance_output, // cell balance drives
  output logic             powered_down_n,  // low while hardware power-down
  output logic             soft_down_n      // low while software power-down
);
  import timer_pkg::*;

  timer_if tif ();
  tick_prescaler #(.TICK_CYCLES(TICK_CYCLES)) u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif.prescaler)
  );

  // ==========================================================================
  // apb decode
  // ==========================================================================
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign pready  = 1'b1;                    // zero wait states
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign addr_ok = (paddr <= ADDR_ON_TIME0 + 8'h14) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !addr_ok;

  logic wr_ctrl;
  logic wr_delay;
  logic wr_bal;
  logic [NUM_OUT-1:0] wr_time;
  assign wr_ctrl  = wr_en && (paddr == ADDR_CONTROL);
  assign wr_delay = wr_en && (paddr == ADDR_SHUT_DELAY);
  assign wr_bal   = wr_en && (paddr == ADDR_BALANCE);

  // ==========================================================================
  // pin filter
  // ==========================================================================
  logic        pin_q;
  logic        pin_filt;
  logic [15:0] flt_cnt;
  logic        first_up;
  logic        pin_fall;
  // filtered level moves only after the raw pin differs for the full interval;
  // at first power-up a shorter interval applies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_filt <= 1'b0;
      flt_cnt  <= '0;
      first_up <= 1'b1;
    end else if (power_down_n == pin_filt) begin
      flt_cnt <= '0;
    end else if ((first_up && flt_cnt == 16'(POWERON_CYCLES - 1))
              || (!first_up && flt_cnt == 16'(FILTER_CYCLES - 1))) begin
      pin_filt <= power_down_n;
      flt_cnt  <= '0;
      first_up <= 1'b0;
    end else begin
      flt_cnt <= flt_cnt + 16'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_q <= 1'b0;
    else          pin_q <= pin_filt;
  end
  assign pin_fall = pin_q && !pin_filt;

  // ==========================================================================
  // control and delay registers
  // ==========================================================================
  logic               soft_bit;
  logic [TIMER_W-1:0] delay_val;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_bit  <= 1'b0;
      delay_val <= TIMER_RESET;
    end else begin
      if (wr_ctrl)  soft_bit  <= pwdata[SOFT_PD_BIT];
      if (wr_delay) delay_val <= pwdata[TIMER_W-1:0];
    end
  end
  logic soft_rise;
  assign soft_rise = wr_ctrl && pwdata[SOFT_PD_BIT] && !soft_bit;

  // ==========================================================================
  // power state and delay timer
  // ==========================================================================
  pwr_state_t         pstate;
  logic [TIMER_W-1:0] delay_cnt;
  logic               delay_soft;   // delay started by the control bit
  logic               expire;
  logic               start;
  assign start  = pin_fall || soft_rise;
  assign expire = (pstate == PWR_DELAY) && (delay_cnt >= delay_val) && !wr_delay;

  // a running delay ignores the pin rising; only expiry ends it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate     <= PWR_ON;
      delay_cnt  <= '0;
      delay_soft <= 1'b0;
    end else begin
      case (pstate)
        PWR_ON: begin
          if (start && delay_val == '0) begin
            pstate <= pin_fall ? PWR_HARD : PWR_SOFT;
          end else if (start) begin
            pstate     <= PWR_DELAY;
            delay_cnt  <= '0;
            delay_soft <= soft_rise && !pin_fall;
          end
        end
        PWR_DELAY: begin
          if (wr_delay) begin
            delay_cnt <= '0;
          end else if (expire) begin
            if (!pin_filt)       pstate <= PWR_HARD;
            else if (delay_soft) pstate <= PWR_SOFT;
            else                 pstate <= PWR_ON;
          end else if (tif.step) begin
            delay_cnt <= delay_cnt + 5'h1;
          end
        end
        PWR_SOFT: begin
          if (!pin_filt)     pstate <= PWR_HARD;
          else if (!soft_bit) pstate <= PWR_ON;
        end
        PWR_HARD: begin
          if (pin_filt) pstate <= soft_bit ? PWR_SOFT : PWR_ON;
        end
        default: pstate <= PWR_ON;
      endcase
    end
  end
  logic going_down;
  assign going_down = (pstate == PWR_HARD) || (pstate == PWR_SOFT);
  assign powered_down_n = (pstate != PWR_HARD);
  assign soft_down_n    = (pstate != PWR_SOFT);

  // ==========================================================================
  // balance register, on-times and shared counter
  // ==========================================================================
  logic [NUM_OUT-1:0] balance;
  logic [TIMER_W-1:0] on_time [NUM_OUT];
  logic [TIMER_W+3:0] bal_cnt;                // steps and sixteenths
  logic               bal_run;
  logic [NUM_OUT-1:0] hit;
  logic               restart;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      assign wr_time[gi] = wr_en && (paddr == ADDR_ON_TIME0 + 8'(4 * gi));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) on_time[gi] <= TIMER_RESET;
        else if (wr_time[gi]) on_time[gi] <= pwdata[TIMER_W-1:0];
      end
      // compare only on the tick; zero means the timer is disabled
      assign hit[gi] = tif.tick && bal_run && (on_time[gi] != '0)
                    && (bal_cnt + 9'h1 >= {on_time[gi], 4'h0});
    end
  endgenerate

  logic active_time_wr;
  assign active_time_wr = |(wr_time & balance);
  assign restart        = (wr_bal && pwdata[NUM_OUT-1:0] != '0) || active_time_wr;
  assign tif.restart    = restart;

  logic [NUM_OUT-1:0] zero_kill;
  always_comb begin
    zero_kill = '0;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (wr_time[i] && pwdata[TIMER_W-1:0] == '0) zero_kill[i] = 1'b1;
    end
  end

  // register write has priority over expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      balance <= BALANCE_RESET;
    end else if (going_down) begin
      balance <= '0;
    end else if (wr_bal) begin
      balance <= pwdata[NUM_OUT-1:0];
    end else if (|(hit & balance)) begin
      balance <= '0;
    end else begin
      balance <= balance & ~zero_kill;
    end
  end

  // shared counter counts ticks while any output is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bal_cnt <= '0;
      bal_run <= 1'b0;
    end else if (restart) begin
      bal_cnt <= '0;
      bal_run <= 1'b1;
    end else if (balance == '0) begin
      bal_cnt <= '0;
      bal_run <= 1'b0;
    end else if (tif.tick) begin
      bal_cnt <= bal_cnt + 9'h1;
    end
  end
  assign balance_output = going_down ? '0 : balance;

  // ==========================================================================
  // read mux
  // ==========================================================================
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      ADDR_CONTROL:    next_prdata = 32'(soft_bit) << SOFT_PD_BIT;
      ADDR_SHUT_DELAY: next_prdata = 32'(delay_val);
      ADDR_BALANCE:    next_prdata = 32'(balance);
      ADDR_STATUS:     next_prdata = {15'h0000, bal_cnt, pstate, 4'h0, pin_filt, 1'b0};
      default: begin
        for (int i = 0; i < NUM_OUT; i++) begin
          if (paddr == ADDR_ON_TIME0 + 8'(4 * i)) next_prdata = 32'(on_time[i]);
        end
      end
    endcase
  end
  // read data registered in the setup cycle so it stands in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= next_prdata;
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  AST_DELAY_ZERO_HARD: assert property (@(posedge pclk) disable iff (!presetn)
    (pstate == PWR_ON && pin_fall && delay_val == '0) |=> pstate == PWR_HARD)
    else $error("zero delay pin fall did not power down");
  AST_RISE_KEEPS_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
    (pstate == PWR_DELAY && !expire) |=> pstate == PWR_DELAY)
    else $error("delay timer left early");
  AST_WR_ZERO_CHECK: assert property (@(posedge pclk) disable iff (!presetn)
    (pstate == PWR_DELAY && wr_delay && pwdata[TIMER_W-1:0] == '0 && !pin_filt)
      |=> ##1 pstate == PWR_HARD)
    else $error("zero delay write did not check pin");
  AST_OUT_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_bal && !going_down) |=> balance == $past(pwdata[NUM_OUT-1:0]))
    else $error("balance write not applied");
  AST_EXPIRE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (|(hit & balance) && !wr_bal && !going_down) |=> balance == '0)
    else $error("expiry did not clear balance");
  AST_DOWN_OUTS_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    going_down |-> (balance_output == '0) ##1 (balance == '0))
    else $error("outputs on while powered down");
  AST_INACTIVE_WR: assert property (@(posedge pclk) disable iff (!presetn)
    (|wr_time && !active_time_wr && !wr_bal && bal_run && balance != '0 && !tif.tick)
      |=> bal_cnt == $past(bal_cnt))
    else $error("inactive on-time write disturbed counter");
  AST_SOFT_ENTER: assert property (@(posedge pclk) disable iff (!presetn)
    (pstate == PWR_ON && soft_rise && !pin_fall && delay_val == '0) |=> pstate == PWR_SOFT)
    else $error("soft power-down not entered");
  AST_FILTER_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!first_up && power_down_n != pin_filt && flt_cnt < 16'(FILTER_CYCLES - 1))
      |=> pin_filt == $past(pin_filt))
    else $error("filter moved early");
endmodule : pd_balance_top

// ### host_model.sv
// host side of the power-down pin: drives the active-low pin and keeps
// the conversion-start line parked; assumes the pin is sampled on pclk
`timescale 1ns/1ps
module host_model #(
  parameter int HOLD_DOWN_CYCLES = 400000  // minimum time the pin is held low
) (
  input  wire logic pclk,             // core clock
  output logic      power_down_n,     // power-down pin, active low
  output logic      convert_start_n   // conversion start, active low
);
  // ==========================================================================
  // pin drive
  // ==========================================================================
  int low_cycles;

  // conversions are never started, so the gate-off and the power-up waits hold
  initial begin
    power_down_n    = 1'b1;
    convert_start_n = 1'b1;
  end

  // cycles spent with the pin low, for the minimum hold-down time
  always @(posedge pclk) begin
    low_cycles <= power_down_n ? 0 : low_cycles + 1;
  end

  // short low pulse that the pin filter must swallow
  task automatic glitch(input int n);
    power_down_n <= 1'b0;
    repeat (n) @(posedge pclk);
    power_down_n <= 1'b1;
  endtask : glitch

  // pin stays low until come_up, which waits only for the hold-down time, not for a running delay to expire
  task automatic go_down();
    power_down_n <= 1'b0;
  endtask : go_down

  // regulator caps need time to discharge before the next power-up
  task automatic come_up();
    while (low_cycles < HOLD_DOWN_CYCLES) @(posedge pclk);
    power_down_n <= 1'b1;
  endtask : come_up
endmodule : host_model

// ### powerdown_and_balance_timers_test.sv
// self-checking bench for the power-down and balance timer block
// assumes a 200 MHz pclk, apb register access and a shortened tick prescaler
`timescale 1ns/1ps
module powerdown_and_balance_timers_test;
  import timer_pkg::*;
  // ==========================================================================
  // signals and instances
  // ==========================================================================
  localparam int TK = 20;  // shortened 4.5 s tick, in cycles
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        power_down_n, powered_down_n, soft_down_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [5:0]  balance_output;
  int          error_cnt, num_checks;

  pd_balance_top #(.TICK_CYCLES(TK)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_n(power_down_n), .balance_output(balance_output),
    .powered_down_n(powered_down_n), .soft_down_n(soft_down_n));
  // hold-down shortened: only the analog side needs the full time
  host_model #(.HOLD_DOWN_CYCLES(2000)) host (
    .pclk(pclk), .power_down_n(power_down_n), .convert_start_n());

  always #2.5 pclk = ~pclk;

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // one apb transfer: setup, then access held until pready at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1);
    check(32'(n), 32'h1, "wait states");
    rdat = prdata;
    err  = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic e;
    apb(1'b0, a, 32'h0, e);
    check(rdat, exp, "register read");
  endtask : rd_chk

  // bounded wait: 0 hard down flag, 1 soft down flag, 2 balance outputs
  task automatic wait_sig(input int sel, input logic [5:0] v, input int lim, input string m);
    logic [5:0] s;
    int n;
    n = 0;
    do begin
      @(posedge pclk); n++;
      s = sel == 0 ? 6'(powered_down_n) : sel == 1 ? 6'(soft_down_n) : balance_output;
    end while (s !== v && n < lim);
    check(32'(s), 32'(v), m);
  endtask : wait_sig

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset_values();
    logic e;
    check(32'(balance_output), 32'h0, "outputs at reset");
    repeat (900) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0, e);
    check(32'(rdat[1]), 32'h0, "pin accepted early");
    repeat (200) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0, e);
    check(32'(rdat[1]), 32'h1, "pin not accepted");
    rd_chk(ADDR_SHUT_DELAY, 32'h0);
    rd_chk(ADDR_BALANCE, 32'h0);
    for (int i = 0; i < 6; i++) rd_chk(ADDR_ON_TIME0 + 8'(4 * i), 32'h0);
    wr(8'h30, 32'hFF);
    apb(1'b0, 8'h30, 32'h0, e);
    check({31'h0, e}, 32'h1, "unmapped read error");
    check(rdat, 32'h0, "unmapped read data");
  endtask : t_reset_values

  task automatic t_balance_follow();
    wr(ADDR_BALANCE, 32'h2A);
    wait_sig(2, 6'h2A, 4, "outputs follow");
    wr(ADDR_BALANCE, 32'h15);
    wait_sig(2, 6'h15, 4, "outputs follow");
    wr(ADDR_BALANCE, 32'h00);
    wait_sig(2, 6'h00, 4, "outputs cleared");
  endtask : t_balance_follow

  task automatic t_balance_timer();
    wr(ADDR_ON_TIME0, 32'h1);
    repeat (4) @(posedge pclk);
    check(32'(balance_output), 32'h0, "armed only");
    wr(ADDR_BALANCE, 32'h1);
    repeat (14 * TK) @(posedge pclk);
    check(32'(balance_output), 32'h1, "on before expiry");
    wait_sig(2, 6'h0, 8 * TK, "off at expiry");
    rd_chk(ADDR_BALANCE, 32'h0);
    rd_chk(ADDR_ON_TIME0, 32'h1);
  endtask : t_balance_timer

  task automatic t_ontime_rewrite();
    logic e;
    wr(ADDR_ON_TIME0 + 8'h4, 32'h3);
    wr(ADDR_BALANCE, 32'h2);
    repeat (8 * TK) @(posedge pclk);
    wr(ADDR_ON_TIME0 + 8'h8, 32'h5);
    apb(1'b0, ADDR_STATUS, 32'h0, e);
    check(32'(rdat[16:8] >= 9'd7), 32'h1, "counter kept");
    wr(ADDR_ON_TIME0 + 8'h4, 32'h2);
    apb(1'b0, ADDR_STATUS, 32'h0, e);
    check(32'(rdat[16:8] <= 9'd1), 32'h1, "counter restarted");
    check(32'(balance_output), 32'h2, "still on");
    wr(ADDR_ON_TIME0 + 8'h4, 32'h0);
    wait_sig(2, 6'h0, 4, "zero on-time turns off");
    for (int i = 0; i < 6; i++) wr(ADDR_ON_TIME0 + 8'(4 * i), 32'h0);
  endtask : t_ontime_rewrite

  task automatic t_soft_delay();
    wr(ADDR_SHUT_DELAY, 32'h2);
    wr(ADDR_CONTROL, 32'h100);
    repeat (20 * TK) @(posedge pclk);
    check(32'(soft_down_n), 32'h1, "delay not elapsed");
    wr(ADDR_SHUT_DELAY, 32'h2);
    repeat (24 * TK) @(posedge pclk);
    check(32'(soft_down_n), 32'h1, "rewrite restarts delay");
    wait_sig(1, 6'h0, 16 * TK, "soft down at expiry");
    check(32'(powered_down_n), 32'h1, "soft keeps supplies");
    wr(ADDR_CONTROL, 32'h0);
    wait_sig(1, 6'h1, 20, "soft exit");
    wr(ADDR_SHUT_DELAY, 32'h3);
    wr(ADDR_CONTROL, 32'h100);
    repeat (4 * TK) @(posedge pclk);
    wr(ADDR_SHUT_DELAY, 32'h0);
    wait_sig(1, 6'h0, 10, "zero delay acts at once");
    wr(ADDR_CONTROL, 32'h0);
    wait_sig(1, 6'h1, 20, "soft exit");
  endtask : t_soft_delay

  task automatic t_hard_down();
    wr(ADDR_BALANCE, 32'h3F);
    host.glitch(200);
    repeat (300) @(posedge pclk);
    check(32'(powered_down_n), 32'h1, "glitch ignored");
    check(32'(balance_output), 32'h3F, "glitch keeps outputs");
    host.go_down();
    repeat (25800) @(posedge pclk);
    check(32'(powered_down_n), 32'h1, "filter too short");
    wait_sig(0, 6'h0, 400, "hard power-down");
    check(32'(balance_output), 32'h0, "outputs off at once");
    host.come_up();
    repeat (25800) @(posedge pclk);
    check(32'(powered_down_n), 32'h0, "exit filter too short");
    wait_sig(0, 6'h1, 400, "hard power-up");
    rd_chk(ADDR_BALANCE, 32'h0);
  endtask : t_hard_down

  // ==========================================================================
  // main sequence and watchdog
  // ==========================================================================
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; error_cnt = 0; num_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_balance_follow();
    t_balance_timer();
    t_ontime_rewrite();
    t_soft_delay();
    t_hard_down();
    end_sim();
  end

  // whole run is about 60k cycles; cut a hang well after that
  initial begin
    #450_000;
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : powerdown_and_balance_timers_test
